// ===== melf_defs.vh
// Constants for the memory error log register bank
`ifndef MELF_DEFS_VH
`define MELF_DEFS_VH

// Register port map: addr[4:2] bank slot, addr[1:0] word in slot
`define MELF_REG_CTRL     8'h80
`define MELF_SLOT_BRIDGE  3'h7
`define MELF_WORD_ST_LO   2'h0
`define MELF_WORD_ST_HI   2'h1
`define MELF_WORD_MI_LO   2'h2
`define MELF_WORD_MI_HI   2'h3
`define MELF_CTRL_RST     2'h3
`define MELF_CTRL_MC_EN   0
`define MELF_CTRL_BR_EN   1

// Detail log field positions
`define MELF_MI_LSB       0
`define MELF_MI_AMODE     6
`define MELF_MI_COL       10
`define MELF_MI_ROW       19
`define MELF_MI_BA0       40
`define MELF_MI_BG1       41
`define MELF_MI_BA1       42
`define MELF_MI_BA2       43
`define MELF_MI_BG2       44
`define MELF_MI_FDEV      46
`define MELF_MI_SRANK     52
`define MELF_MI_RANK      56
`define MELF_MI_ECC       59
`define MELF_MI_TRANS     63

// Correction scheme encodings
`define MELF_ECC_SDC_MODE 4'h0
`define MELF_ECC_SDC      4'h1
`define MELF_ECC_ADC_MODE 4'h4
`define MELF_ECC_ADC      4'h5
`define MELF_ECC_PM_RD    4'h8

// Status log field positions
`define MELF_ST_CODE_ONE  7
`define MELF_ST_REQ       4
`define MELF_ST_CHAN      0
`define MELF_ST_MSCOD     16
`define MELF_ST_RD        16
`define MELF_ST_PW        18
`define MELF_ST_FW        19
`define MELF_ST_CB        20
`define MELF_ST_TO        21
`define MELF_ST_PAR       22
`define MELF_ST_B1        23
`define MELF_ST_CTYPE     24
`define MELF_ST_MISC      26
`define MELF_ST_OVF       62
`define MELF_ST_VAL       63

`endif

// ===== melf_error_log.v
// Memory controller and bridge error log register bank
`timescale 1ns/100ps
`include "melf_defs.vh"

module melf_error_log #(
  parameter BANKS      = 3,
  parameter BANK_SEL_W = 2,
  parameter FIRST_BANK = 13,
  parameter BRIDGE_BANK = 12
) (
  input  wire                  clock,
  input  wire                  rst,
  input  wire [7:0]            addr,
  input  wire [31:0]           wdata,
  input  wire                  wr,
  input  wire                  rd,
  output reg  [31:0]           rdata,
  input  wire                  mc_evt,
  input  wire [BANK_SEL_W-1:0] mc_bank,
  input  wire [2:0]            mc_req_type,
  input  wire [3:0]            mc_chan,
  input  wire [15:0]           mc_mscod,
  input  wire                  mc_uncorr,
  input  wire                  mc_transient,
  input  wire [5:0]            mc_lsb,
  input  wire [2:0]            mc_amode,
  input  wire [6:0]            mc_col,
  input  wire [20:0]           mc_row,
  input  wire [2:0]            mc_bank_addr,
  input  wire [1:0]            mc_bank_grp,
  input  wire [5:0]            mc_fail_dev,
  input  wire [3:0]            mc_sub_rank,
  input  wire [2:0]            mc_rank,
  input  wire [3:0]            mc_ecc_mode,
  input  wire                  br_evt,
  input  wire                  br_mirror_evt,
  input  wire [2:0]            br_req_type,
  input  wire [3:0]            br_chan,
  input  wire [6:0]            br_flags,
  input  wire [1:0]            br_chan_type_err,
  input  wire [5:0]            br_misc_err,
  output wire [BANKS-1:0]      mc_valid,
  output wire                  br_valid
);

  // Bank numbers as software sees them
  localparam [7:0] MC_FIRST_NUM = FIRST_BANK[7:0];
  localparam [7:0] BR_NUM       = BRIDGE_BANK[7:0];

  reg  [1:0]          ctrl_r;
  reg  [63:0]         br_st_r;
  reg  [63:0]         br_mi_r;
  reg  [63:0]         br_st_nxt;
  reg  [31:0]         rd_nxt;
  wire [64*BANKS-1:0] st_flat;
  wire [64*BANKS-1:0] mi_flat;
  wire [63:0]         mc_st_word;
  wire [63:0]         mc_mi_word;
  wire [15:0]         br_code_set;
  wire                mc_log;
  wire                br_log;
  wire                br_clr;
  wire [2:0]          slot;
  wire                in_banks;

  // Compound code: eight zeros, a one, request type, channel
  function [15:0] code16;
    input [2:0] req;
    input [3:0] chan;
    reg   [15:0] c;
    begin
      c = 16'h0000;
      c[`MELF_ST_CODE_ONE] = 1'b1;
      c[`MELF_ST_REQ +: 3] = req;
      c[`MELF_ST_CHAN +: 4] = chan;
      code16 = c;
    end
  endfunction

  // Bridge model-specific field, bits 31:16 of status
  function [15:0] br_mscod;
    input [6:0] fl;
    input [1:0] ctype;
    input [5:0] misc;
    reg   [15:0] m;
    begin
      m = 16'h0000;
      m[`MELF_ST_RD - 16] = fl[0];
      m[`MELF_ST_PW - 16] = fl[1];
      m[`MELF_ST_FW - 16] = fl[2];
      m[`MELF_ST_CB - 16] = fl[3];
      m[`MELF_ST_TO - 16] = fl[4];
      m[`MELF_ST_PAR - 16] = fl[5];
      m[`MELF_ST_B1 - 16] = fl[6];
      m[`MELF_ST_CTYPE - 16 +: 2] = ctype;
      m[`MELF_ST_MISC - 16 +: 6] = misc;
      br_mscod = m;                                   // Bit 17 left zero
    end
  endfunction

  // Reserved correction scheme codes are logged as zero
  function [3:0] ecc_legal;
    input [3:0] e;
    begin
      case (e)
        `MELF_ECC_SDC_MODE,
        `MELF_ECC_SDC,
        `MELF_ECC_ADC_MODE,
        `MELF_ECC_ADC,
        `MELF_ECC_PM_RD: ecc_legal = e;
        default:         ecc_legal = 4'h0;
      endcase
    end
  endfunction

  // Memory bank detail record
  function [63:0] misc_word;
    input [5:0]  lsb;
    input [2:0]  amode;
    input [6:0]  col;
    input [20:0] row;
    input [2:0]  ba;
    input [1:0]  bg;
    input [5:0]  fdev;
    input        uncorr;
    input        trans;
    input [3:0]  srank;
    input [2:0]  rank;
    input [3:0]  ecc;
    reg   [63:0] m;
    begin
      m = 64'h0000000000000000;
      m[`MELF_MI_LSB +: 6] = lsb;
      m[`MELF_MI_AMODE +: 3] = amode;
      m[`MELF_MI_COL +: 7] = col;
      m[`MELF_MI_ROW +: 21] = row;
      m[`MELF_MI_BA0] = ba[0];
      m[`MELF_MI_BA1] = ba[1];
      m[`MELF_MI_BA2] = ba[2];
      m[`MELF_MI_BG1] = bg[0];
      m[`MELF_MI_BG2] = bg[1];
      if (!uncorr && !trans) begin
        m[`MELF_MI_FDEV +: 6] = fdev;
      end
      m[`MELF_MI_SRANK +: 4] = srank;
      m[`MELF_MI_RANK +: 3] = rank;
      m[`MELF_MI_ECC +: 4] = ecc_legal(ecc);
      m[`MELF_MI_TRANS] = trans;
      misc_word = m;
    end
  endfunction

  assign mc_log      = mc_evt & ctrl_r[`MELF_CTRL_MC_EN];
  assign br_log      = br_evt & ctrl_r[`MELF_CTRL_BR_EN];
  assign br_code_set = br_mscod(br_flags, br_chan_type_err, br_misc_err);
  assign mc_st_word  = {1'b1, 31'h00000000, mc_mscod,
                        code16(mc_req_type, mc_chan)};
  assign mc_mi_word  = misc_word(mc_lsb, mc_amode, mc_col, mc_row, mc_bank_addr,
                                 mc_bank_grp, mc_fail_dev, mc_uncorr, mc_transient,
                                 mc_sub_rank, mc_rank, mc_ecc_mode);
  assign slot        = addr[4:2];
  assign in_banks    = (addr[7:5] == 3'h0) && ({29'h0, slot} < BANKS);
  assign br_clr      = wr && (addr[7:5] == 3'h0) && (slot == `MELF_SLOT_BRIDGE) &&
                       (addr[1:0] == `MELF_WORD_ST_HI);

  // Memory controller banks
  genvar b;
  generate
    for (b = 0; b < BANKS; b = b + 1) begin : g_bank
      reg  [63:0] st_r;
      reg  [63:0] mi_r;
      wire        hit;
      wire        clr;
      assign hit = mc_log && ({{(32-BANK_SEL_W){1'b0}}, mc_bank} == b);
      assign clr = wr && (addr[7:5] == 3'h0) && ({29'h0, slot} == b) &&
                   (addr[1:0] == `MELF_WORD_ST_HI);
      always @(posedge clock) begin
        if (rst) begin
          st_r <= 64'h0000000000000000;
          mi_r <= 64'h0000000000000000;
        end else if (hit && (!st_r[`MELF_ST_VAL] || clr)) begin
          // Status and detail change together; new event beats clear
          st_r <= mc_st_word;
          mi_r <= mc_mi_word;
        end else if (hit) begin
          // First record kept, later one only flagged
          st_r[`MELF_ST_OVF] <= 1'b1;
        end else if (clr) begin
          st_r <= 64'h0000000000000000;
          mi_r <= 64'h0000000000000000;
        end
      end
      assign st_flat[64*b +: 64] = st_r;
      assign mi_flat[64*b +: 64] = mi_r;
      assign mc_valid[b]         = st_r[`MELF_ST_VAL];
    end
  endgenerate

  // Bridge bank status next value
  always @* begin
    br_st_nxt = br_st_r;
    if (br_log && (!br_st_r[`MELF_ST_VAL] || br_clr)) begin
      br_st_nxt = {1'b1, 31'h00000000, br_code_set,
                   code16(br_req_type, br_chan)};
    end else if (br_log) begin
      br_st_nxt[`MELF_ST_OVF] = 1'b1;
    end else if (br_clr) begin
      br_st_nxt = 64'h0000000000000000;
    end
  end

  // Bridge bank registers and control
  always @(posedge clock) begin
    if (rst) begin
      br_st_r <= 64'h0000000000000000;
      br_mi_r <= 64'h0000000000000000;
      ctrl_r  <= `MELF_CTRL_RST;
    end else begin
      br_st_r <= br_st_nxt;
      if (br_mirror_evt) begin
        // Mirror corrections use the bridge code set
        br_mi_r <= {32'h00000000, br_code_set,
                    code16(br_req_type, br_chan)};
      end
      if (wr && (addr == `MELF_REG_CTRL)) begin
        ctrl_r <= wdata[1:0];
      end
    end
  end

  assign br_valid = br_st_r[`MELF_ST_VAL];

  // Read decode
  always @* begin
    rd_nxt = 32'h00000000;
    if (addr == `MELF_REG_CTRL) begin
      rd_nxt = {8'h00, MC_FIRST_NUM, BR_NUM, 6'h00, ctrl_r};
    end else if (in_banks) begin
      case (addr[1:0])
        `MELF_WORD_ST_LO: rd_nxt = st_flat[64*slot +: 32];
        `MELF_WORD_ST_HI: rd_nxt = st_flat[64*slot + 32 +: 32];
        `MELF_WORD_MI_LO: rd_nxt = mi_flat[64*slot +: 32];
        default:          rd_nxt = mi_flat[64*slot + 32 +: 32];
      endcase
    end else if ((addr[7:5] == 3'h0) && (slot == `MELF_SLOT_BRIDGE)) begin
      case (addr[1:0])
        `MELF_WORD_ST_LO: rd_nxt = br_st_r[31:0];
        `MELF_WORD_ST_HI: rd_nxt = br_st_r[63:32];
        `MELF_WORD_MI_LO: rd_nxt = br_mi_r[31:0];
        default:          rd_nxt = br_mi_r[63:32];
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      rdata <= rd_nxt;
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule // melf_error_log

// ===== melf_error_log_checker.sv
// Port assertions for the error log register bank
`timescale 1ns/100ps
module melf_log_checker #(
  parameter BANKS      = 3,
  parameter BANK_SEL_W = 2
) (
  input wire                  clock,
  input wire                  rst,
  input wire [7:0]            addr,
  input wire [31:0]           wdata,
  input wire                  wr,
  input wire                  rd,
  input wire [31:0]           rdata,
  input wire                  mc_evt,
  input wire [BANK_SEL_W-1:0] mc_bank,
  input wire                  br_evt,
  input wire [BANKS-1:0]      mc_valid,
  input wire                  br_valid
);
  reg mc_en_r;
  reg br_en_r;
  // Shadow of the logging enables
  always @(posedge clock) begin
    if (rst) begin
      mc_en_r <= 1'b1;
      br_en_r <= 1'b1;
    end else if (wr && addr == 8'h80) begin
      mc_en_r <= wdata[0];
      br_en_r <= wdata[1];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_log0;
    mc_evt && mc_en_r && mc_bank == 0;
  endsequence
  sequence s_clr0;
    wr && addr == 8'h01 && !mc_evt;
  endsequence
  log_sets_valid_a: assert property (s_log0 |=> mc_valid[0])
    else $error("event not logged");
  clear_valid_a: assert property (s_clr0 |=> !mc_valid[0])
    else $error("clear ignored");
  valid_holds_a: assert property (mc_valid[0] && !(wr && addr == 8'h01) |=> mc_valid[0])
    else $error("valid dropped");
  valid_cause_a: assert property (|(mc_valid & ~$past(mc_valid)) |-> $past(mc_evt))
    else $error("valid without event");
  br_log_a: assert property (br_evt && br_en_r |=> br_valid)
    else $error("bridge event not logged");
  read_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside slot");
  status_valid_a: assert property (rd && addr == 8'h01 |=> rdata[31] == $past(mc_valid[0]))
    else $error("valid bit differs");
  code_form_a: assert property (rd && addr == 8'h1c && br_valid |=>
    rdata[15:7] == 9'h001 && !rdata[17])
    else $error("bridge code malformed");
endmodule // melf_log_checker
bind melf_error_log melf_log_checker #(.BANKS(BANKS), .BANK_SEL_W(BANK_SEL_W)) u_chk (
  .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .mc_evt(mc_evt), .mc_bank(mc_bank), .br_evt(br_evt), .mc_valid(mc_valid),
  .br_valid(br_valid));

// ===== melf_channel_model.sv
// Memory channel model raising logged error events
`timescale 1ns/100ps
module melf_channel_model (
  input  wire        clock,
  output reg         mc_evt,
  output reg  [1:0]  mc_bank,
  output reg  [83:0] mc_fields
);
  initial begin
    mc_evt    = 1'b0;
    mc_bank   = 2'h0;
    mc_fields = 84'h0;
  end
  // Fields churn between events
  always @(negedge clock) begin
    if (!mc_evt) begin
      mc_fields <= ~mc_fields;
    end
  end
  task fire(input [1:0] b, input [83:0] f);
    begin
      @(posedge clock);
      mc_evt    <= 1'b1;
      mc_bank   <= b;
      mc_fields <= f;
      @(posedge clock);
      mc_evt <= 1'b0;
    end
  endtask
endmodule // melf_channel_model

// ===== melf_tb.sv
// Self-checking bench for the error log register bank
`timescale 1ns/100ps
module testbench;
  reg         clock = 1'b0;
  reg         rst   = 1'b1;
  reg  [7:0]  addr  = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         wr    = 1'b0;
  reg         rd    = 1'b0;
  reg  [21:0] bf    = 22'h0;
  reg         br_evt = 1'b0;
  reg         br_mirror_evt = 1'b0;
  reg  [83:0] f;
  reg  [63:0] got;
  reg  [31:0] r;
  reg  [7:0]  a;
  wire [31:0] rdata;
  wire        mc_evt;
  wire [1:0]  mc_bank;
  wire [83:0] mf;
  wire [2:0]  mc_valid;
  wire        br_valid;
  integer     mismatches = 0;
  integer     n_compared = 0;
  integer     i;
  always #20 clock = ~clock;
  melf_channel_model ch (.clock(clock), .mc_evt(mc_evt), .mc_bank(mc_bank), .mc_fields(mf));
  melf_error_log dut (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .mc_evt(mc_evt), .mc_bank(mc_bank), .mc_req_type(mf[67:65]), .mc_chan(mf[64:61]),
    .mc_mscod(mf[83:68]), .mc_uncorr(mf[60]), .mc_transient(mf[59]), .mc_lsb(mf[58:53]),
    .mc_amode(mf[52:50]), .mc_col(mf[49:43]), .mc_row(mf[42:22]), .mc_bank_addr(mf[21:19]),
    .mc_bank_grp(mf[18:17]), .mc_fail_dev(mf[16:11]), .mc_sub_rank(mf[10:7]),
    .mc_rank(mf[6:4]), .mc_ecc_mode(mf[3:0]), .br_evt(br_evt), .br_mirror_evt(br_mirror_evt),
    .br_req_type(bf[6:4]), .br_chan(bf[3:0]), .br_flags(bf[13:7]),
    .br_chan_type_err(bf[15:14]), .br_misc_err(bf[21:16]), .mc_valid(mc_valid),
    .br_valid(br_valid));
  function [63:0] exp_det(input [83:0] v);
    reg ok;
    begin
      ok = v[3:0] == 4'h0 || v[3:0] == 4'h1 || v[3:0] == 4'h4 || v[3:0] == 4'h5 || v[3:0] == 4'h8;
      exp_det = {v[59], ok ? v[3:0] : 4'h0, v[6:4], v[10:7], (v[60] | v[59]) ? 6'h0 : v[16:11],
        1'b0, v[18], v[21:20], v[17], v[19], v[42:22], 2'h0, v[49:43], 1'b0, v[52:50], v[58:53]};
    end
  endfunction
  function [63:0] exp_st(input [83:0] v, input ovf);
    exp_st = {1'b1, ovf, 30'h0, v[83:68], 8'h00, 1'b1, v[67:61]};
  endfunction
  function [31:0] exp_br(input [21:0] b);
    exp_br = {b[21:14], b[13:8], 1'b0, b[7], 8'h00, 1'b1, b[6:0]};
  endfunction
  task rd32(input [7:0] ad, output [31:0] d);
    begin
      @(posedge clock);
      rd   <= 1'b1;
      addr <= ad;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task rd64(input [7:0] ad, output [63:0] v);
    begin
      rd32(ad, v[31:0]);
      rd32(ad + 8'h01, v[63:32]);
    end
  endtask
  task wr32(input [7:0] ad, input [31:0] d);
    begin
      @(posedge clock);
      wr    <= 1'b1;
      addr  <= ad;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
    end
  endtask
  task chk(input [63:0] g, input [63:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task conclude;
    begin
      $display("Compared %0d, mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    r = $urandom(27);
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd32(8'h80, r);
    chk({32'h0, r}, {32'h0, 8'h00, 8'h0d, 8'h0c, 6'h00, 2'h3});
    for (i = 0; i < 15; i = i + 1) begin
      f = {$urandom, $urandom, $urandom};
      if (i < 6) f[3:0] = 4'(24'h285410 >> (4 * i));
      a = 8'((i % 3) * 4);
      ch.fire(a[3:2], f);
      rd64(a, got);
      chk(got, exp_st(f, 1'b0));
      chk({61'h0, mc_valid}, 64'h1 << (i % 3));
      rd64(a + 8'h02, got);
      chk(got, exp_det(f));
      wr32(a + 8'h01, 32'h0);
      rd64(a, got);
      chk(got, 64'h0);
    end
    $display("Test random_records done");
    ch.fire(2'h1, f);
    ch.fire(2'h1, ~f);
    rd64(8'h04, got);
    chk(got, exp_st(f, 1'b1));
    rd64(8'h06, got);
    chk(got, exp_det(f));
    wr32(8'h05, 32'h0);
    wr32(8'h80, 32'h2);
    ch.fire(2'h0, f);
    rd64(8'h00, got);
    chk(got, 64'h0);
    wr32(8'h80, 32'h3);
    rd64(8'h40, got);
    chk(got, 64'h0);
    $display("Test overflow_gating done");
    for (i = 0; i < 8; i = i + 1) begin
      r = $urandom;
      @(posedge clock);
      bf     <= {r[21:14], 7'h1 << i, r[6:0]};
      br_evt <= 1'b1;
      @(posedge clock);
      br_evt <= 1'b0;
      rd64(8'h1c, got);
      chk(got, {32'h80000000, exp_br(bf)});
      chk({63'h0, br_valid}, 64'h1);
      wr32(8'h1d, 32'h0);
    end
    @(posedge clock);
    bf            <= {8'h00, 7'h7f, r[6:0]};
    br_mirror_evt <= 1'b1;
    @(posedge clock);
    br_mirror_evt <= 1'b0;
    rd64(8'h1e, got);
    chk(got, {32'h0, exp_br(bf)});
    $display("Test bridge done");
    conclude;
  end
  initial begin
    #(40 * 4000);
    mismatches = mismatches + 1;
    conclude;
  end
endmodule // testbench
